// *** logic/lfd_ctrl.sv ***
/*
 * Top of the LED fade and dimming controller: register port, enable
 * debouncing, channel latches, internal gamma pwm, aux channel and supply
 * handling. Assumes one 50 MHz clock; pins and supply flags are asynchronous
 * and are synchronised here; timing pins arrive as 8-bit digitised values.
 */
`default_nettype none
module lfd_ctrl import lfd_pkg::*; #(
    parameter int DEBOUNCE_CYC = DEB_CYC,
    parameter int STEP_UNIT_CYC = FADE_UNIT_CYC,
    parameter int INSTANT_CYC = INSTANT_STEP_CYC,
    parameter int PRESC_CYC = PWM_PRESC_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [1:0] main_channel_enable_pins,
    input wire logic aux_channel_enable,
    input wire logic [7:0] fade_on_timing_pin,
    input wire logic [7:0] fade_off_timing_pin,
    input wire logic undervoltage,
    input wire logic supply_lost,
    output logic [1:0] main_led_outputs,
    output logic [15:0] main_current_codes,
    output logic aux_led_output,
    output logic [3:0] aux_current_scale
);
    typedef struct packed {
        logic [1:0] en_s1;
        logic [1:0] en_s2;
        logic aux_s1;
        logic aux_s2;
        logic uv_s1;
        logic uv_s2;
        logic lost_s1;
        logic lost_s2;
        logic [7:0] ton_s1;
        logic [7:0] ton_s2;
        logic [7:0] toff_s1;
        logic [7:0] toff_s2;
        logic [7:0] cfg;
        logic [7:0] aux;
        logic [7:0] fon;
        logic [7:0] foff;
        logic [1:0][7:0] cur;
        logic group;
        logic [1:0] on;
        logic [7:0] pre;
        logic [9:0] pwm;
        logic [7:0] rdata;
        logic [1:0] gate;
        logic aux_out;
        logic [3:0] aux_scale;
    } lfd_ctrl_t;
    lfd_ctrl_t s_q, s_d;

    logic [2:0] deb_in, deb_lvl, deb_rise, deb_fall;
    logic [1:0] cmd_on, cmd_off;
    logic [1:0][5:0] step;
    logic [23:0] on_ivl, off_ivl;
    logic pulse_mode, ext_mode;

    // zero selects the near-instant step time, otherwise count times unit
    function automatic logic [23:0] step_ivl(input logic [7:0] cnt);
        if (cnt == 8'h00) return 24'(INSTANT_CYC);
        return 24'(cnt) * 24'(STEP_UNIT_CYC);
    endfunction

    assign pulse_mode = s_q.cfg[CFG_SW_MODE];
    assign ext_mode = s_q.cfg[CFG_DIM_EXT];

    // register or pin source for each fade direction
    assign on_ivl = step_ivl(s_q.cfg[CFG_FON_SRC] ? s_q.fon : s_q.ton_s2);
    assign off_ivl = step_ivl(s_q.cfg[CFG_FOFF_SRC] ? s_q.foff : s_q.toff_s2);

    // two enable pins and the group bit all pass the same filter, even when fades are cancelled
    assign deb_in = {s_q.group, s_q.en_s2};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_deb
            lfd_debounce #(
                .CYC(DEBOUNCE_CYC)
            ) u_deb (
                .clk(clk),
                .rst_n(rst_n),
                .din(deb_in[gi]),
                .level(deb_lvl[gi]),
                .rise(deb_rise[gi]),
                .fall(deb_fall[gi])
            );
        end
    endgenerate

    // per-channel commands; the register group bit outranks the pin
    always_comb begin
        cmd_on = '0;
        cmd_off = '0;
        for (int i = 0; i < 2; i++) begin
            if (!ext_mode && deb_rise[2]) begin
                cmd_on[i] = 1'b1;
            end else if (!ext_mode && deb_fall[2]) begin
                cmd_off[i] = 1'b1;
            end else if (pulse_mode) begin
                // a qualified low press flips the latch
                cmd_on[i] = deb_fall[i] & ~s_q.on[i];
                cmd_off[i] = deb_fall[i] & s_q.on[i];
            end else begin
                // rising turns on only if off, falling off only if on
                cmd_on[i] = deb_rise[i] & ~s_q.on[i];
                cmd_off[i] = deb_fall[i] & s_q.on[i];
            end
        end
    end

    // one ramp engine per channel, fed only by its own commands
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            lfd_ramp_if rif ();
            assign rif.cmd_on = cmd_on[gi];
            assign rif.cmd_off = cmd_off[gi];
            assign rif.clear = s_q.lost_s2;
            assign rif.on_ivl = on_ivl;
            assign rif.off_ivl = off_ivl;
            assign step[gi] = rif.step;
            lfd_ramp u_ramp (
                .clk(clk),
                .rst_n(rst_n),
                .rif(rif.eng)
            );
        end
    endgenerate

    // state update: synchronisers, registers, latches, pwm and outputs
    always_comb begin
        s_d = s_q;
        // pin synchronisers, first stage read only by the second
        s_d.en_s1 = main_channel_enable_pins;
        s_d.en_s2 = s_q.en_s1;
        s_d.aux_s1 = aux_channel_enable;
        s_d.aux_s2 = s_q.aux_s1;
        s_d.uv_s1 = undervoltage;
        s_d.uv_s2 = s_q.uv_s1;
        s_d.lost_s1 = supply_lost;
        s_d.lost_s2 = s_q.lost_s1;
        s_d.ton_s1 = fade_on_timing_pin;
        s_d.ton_s2 = s_q.ton_s1;
        s_d.toff_s1 = fade_off_timing_pin;
        s_d.toff_s2 = s_q.toff_s1;

        // register writes
        if (wr) begin
            if (addr == ADDR_CFG) begin
                s_d.cfg = wdata;
            end else if (addr == ADDR_AUX) begin
                s_d.aux = wdata;
            end else if (addr == ADDR_FON) begin
                s_d.fon = wdata;
            end else if (addr == ADDR_FOFF) begin
                s_d.foff = wdata;
            end else if (addr == ADDR_CUR1) begin
                s_d.cur[0] = wdata;
            end else if (addr == ADDR_CUR2) begin
                s_d.cur[1] = wdata;
            end else if (addr == ADDR_DIM) begin
                s_d.group = wdata[DIM_GROUP_BIT];
            end
        end

        // read data valid in the cycle after the strobe only
        s_d.rdata = 8'h00;
        if (rd) begin
            if (addr == ADDR_CFG) begin
                s_d.rdata = s_q.cfg;
            end else if (addr == ADDR_AUX) begin
                s_d.rdata = s_q.aux;
            end else if (addr == ADDR_FON) begin
                s_d.rdata = s_q.fon;
            end else if (addr == ADDR_FOFF) begin
                s_d.rdata = s_q.foff;
            end else if (addr == ADDR_CUR1) begin
                s_d.rdata = s_q.cur[0];
            end else if (addr == ADDR_CUR2) begin
                s_d.rdata = s_q.cur[1];
            end else if (addr == ADDR_DIM) begin
                // low bits are status only
                s_d.rdata = {s_q.group, 4'h0, s_q.uv_s2, s_q.on};
            end else if (addr == ADDR_STEP) begin
                s_d.rdata = {2'b00, (s_q.on[1] ? step[1] : step[0])};
            end
        end

        // latched channel states follow the commands, supply loss wipes them
        for (int i = 0; i < 2; i++) begin
            if (cmd_on[i]) s_d.on[i] = 1'b1;
            else if (cmd_off[i]) s_d.on[i] = 1'b0;
        end
        if (s_q.lost_s2) s_d.on = 2'b00;

        // internal pwm: prescaler then a 0..999 phase counter
        if (s_q.pre == 8'(PRESC_CYC - 1)) begin
            s_d.pre = 8'h00;
            s_d.pwm = (s_q.pwm == 10'(PWM_FULL - 1)) ? 10'd0 : s_q.pwm + 10'd1;
        end else begin
            s_d.pre = s_q.pre + 8'h01;
        end

        // main gates; undervoltage forces them off but keeps the latches
        for (int i = 0; i < 2; i++) begin
            if (s_q.uv_s2) begin
                s_d.gate[i] = 1'b0;
            end else if (ext_mode) begin
                s_d.gate[i] = s_q.group;
            end else begin
                s_d.gate[i] = s_q.pwm < GAMMA[step[i]];
            end
        end

        // aux channel: pin or bit, no ramp, so a pwm on the pin passes through
        s_d.aux_out = ~s_q.uv_s2 & (s_q.aux_s2 | s_q.aux[AUX_EN_BIT]);
        s_d.aux_scale = (s_q.aux[2:0] == 3'd0) ? 4'd8 : {1'b0, s_q.aux[2:0]};
    end

    // all state clears at reset, latches to off; fade registers and aux scale load their reset values
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.cfg <= CFG_RST;
            s_q.aux <= AUX_RST;
            s_q.fon <= FADE_RST;
            s_q.foff <= FADE_RST;
            s_q.cur <= {CUR_RST, CUR_RST};
            s_q.aux_scale <= 4'd8;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign main_led_outputs = s_q.gate;
    assign main_current_codes = s_q.cur;
    assign aux_led_output = s_q.aux_out;
    assign aux_current_scale = s_q.aux_scale;
endmodule
`default_nettype wire

// *** logic/lfd_debounce.sv ***
/*
 * Stable-level debounce filter with edge pulses.
 * Assumes the input is already synchronised to clk.
 */
`default_nettype none
module lfd_debounce import lfd_pkg::*; #(
    parameter int CYC = DEB_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic lvl;
        logic rise;
        logic fall;
        logic [23:0] cnt;
    } lfd_deb_t;
    lfd_deb_t s_q, s_d;

    // a new level is taken only after it held for the whole interval
    always_comb begin
        s_d = s_q;
        s_d.rise = 1'b0;
        s_d.fall = 1'b0;
        if (din == s_q.lvl) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == 24'(CYC - 1)) begin
            s_d.cnt = '0;
            s_d.lvl = din;
            s_d.rise = din;
            s_d.fall = ~din;
        end else begin
            s_d.cnt = s_q.cnt + 24'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) s_q <= '0;
        else s_q <= s_d;
    end

    assign level = s_q.lvl;
    assign rise = s_q.rise;
    assign fall = s_q.fall;
endmodule
`default_nettype wire

// *** logic/lfd_pkg.sv ***
/*
 * Constants, register map and gamma table of the LED fade and dimming controller.
 * Assumes a single 50 MHz clock shared by all modules that import it.
 */
`default_nettype none
package lfd_pkg;
    localparam int CLK_MHZ = 50;
    localparam int DEB_TIME_US = 37000;
    localparam int DEB_CYC = DEB_TIME_US * CLK_MHZ;
    localparam int GAMMA_LAST = 62;
    localparam int FADE_UNIT_US = 7000;
    localparam int FADE_UNIT_CYC = FADE_UNIT_US * CLK_MHZ / GAMMA_LAST;
    localparam int INSTANT_TIME_NS = 75000;
    localparam int INSTANT_STEP_CYC = INSTANT_TIME_NS * CLK_MHZ / 1000 / GAMMA_LAST;
    localparam int PWM_FREQ_HZ = 220;
    localparam int PWM_FULL = 1000;
    localparam int PWM_PRESC_CYC = CLK_MHZ * 1000000 / PWM_FREQ_HZ / PWM_FULL;
    localparam int IVL_W = 24;

    // register offsets
    localparam logic [7:0] ADDR_CFG = 8'h01;
    localparam logic [7:0] ADDR_AUX = 8'h02;
    localparam logic [7:0] ADDR_FON = 8'h03;
    localparam logic [7:0] ADDR_FOFF = 8'h04;
    localparam logic [7:0] ADDR_CUR1 = 8'h05;
    localparam logic [7:0] ADDR_CUR2 = 8'h06;
    localparam logic [7:0] ADDR_DIM = 8'h07;
    localparam logic [7:0] ADDR_STEP = 8'h0b;

    // field positions
    localparam int CFG_SW_MODE = 0;
    localparam int CFG_DIM_EXT = 1;
    localparam int CFG_FOFF_SRC = 2;
    localparam int CFG_FON_SRC = 3;
    localparam int AUX_EN_BIT = 4;
    localparam int DIM_GROUP_BIT = 7;
    localparam int DIM_UV_BIT = 2;

    // reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [7:0] FADE_RST = 8'h64;
    localparam logic [7:0] CUR_RST = 8'h00;

    // gamma levels on a 0..1000 scale, entry 62 listed first
    localparam logic [62:0][9:0] GAMMA = {
        10'd1000, 10'd956, 10'd914, 10'd874, 10'd836, 10'd798, 10'd760,
        10'd722, 10'd684, 10'd654, 10'd624, 10'd594, 10'd564, 10'd534, 10'd504,
        10'd482, 10'd460, 10'd438, 10'd416, 10'd394, 10'd372, 10'd354, 10'd336,
        10'd318, 10'd300, 10'd282, 10'd264, 10'd250, 10'd236, 10'd222, 10'd208,
        10'd194, 10'd180, 10'd170, 10'd160, 10'd150, 10'd140, 10'd130, 10'd120,
        10'd112, 10'd104, 10'd96, 10'd88, 10'd80, 10'd72, 10'd66, 10'd60,
        10'd54, 10'd48, 10'd42, 10'd36, 10'd32, 10'd28, 10'd24, 10'd20,
        10'd16, 10'd12, 10'd10, 10'd8, 10'd6, 10'd4, 10'd2, 10'd0};
endpackage
`default_nettype wire

// *** logic/lfd_ramp.sv ***
/*
 * Gamma step engine of one main channel: walks step 0..62 up or down.
 * Assumes interval values of at least one cycle from the controller.
 */
`default_nettype none
module lfd_ramp import lfd_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    lfd_ramp_if.eng rif
);
    typedef struct packed {
        logic up;
        logic [5:0] step;
        logic [23:0] tmr;
    } lfd_ramp_t;
    lfd_ramp_t s_q, s_d;
    logic [23:0] ivl;

    // one step per interval; a new command reverses from where it is
    always_comb begin
        s_d = s_q;
        ivl = s_q.up ? rif.on_ivl : rif.off_ivl;
        if (rif.clear) begin
            s_d = '0;
        end else if (rif.cmd_on || rif.cmd_off) begin
            s_d.up = rif.cmd_on;
            s_d.tmr = '0;
        end else if (s_q.tmr >= ivl - 24'd1) begin
            s_d.tmr = '0;
            if (s_q.up && s_q.step != 6'(GAMMA_LAST)) s_d.step = s_q.step + 6'd1;
            else if (!s_q.up && s_q.step != 6'd0) s_d.step = s_q.step - 6'd1;
        end else begin
            s_d.tmr = s_q.tmr + 24'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) s_q <= '0;
        else s_q <= s_d;
    end

    assign rif.step = s_q.step;
endmodule
`default_nettype wire

// *** logic/lfd_ramp_if.sv ***
/*
 * Command and status bundle between the controller and one ramp engine.
 * Assumes both ends sit on the same clock.
 */
`default_nettype none
interface lfd_ramp_if;
    logic cmd_on;
    logic cmd_off;
    logic clear;
    logic [23:0] on_ivl;
    logic [23:0] off_ivl;
    logic [5:0] step;
    modport ctl (output cmd_on, output cmd_off, output clear, output on_ivl, output off_ivl, input step);
    modport eng (input cmd_on, input cmd_off, input clear, input on_ivl, input off_ivl, output step);
endinterface
`default_nettype wire

// *** verif/lfd_ctrl_sva.sv ***
/* Port-level checker for the LED fade and dimming controller.
   Assumes it is bound into lfd_ctrl, one clock, sync active-low reset. */
`default_nettype none
module lfd_ctrl_sva import lfd_pkg::*; #(
    parameter int DEBOUNCE_CYC = DEB_CYC,
    parameter int STEP_UNIT_CYC = FADE_UNIT_CYC,
    parameter int INSTANT_CYC = INSTANT_STEP_CYC,
    parameter int PRESC_CYC = PWM_PRESC_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic aux_channel_enable,
    input wire logic undervoltage,
    input wire logic supply_lost,
    input wire logic [1:0] main_led_outputs,
    input wire logic aux_led_output,
    input wire logic [3:0] aux_current_scale
);
    logic ext_q, aux_q, dim_q;
    logic [3:0] sc_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // shadow of the few register bits the properties depend on
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_q <= 1'b0;
            aux_q <= 1'b0;
            dim_q <= 1'b0;
            sc_q <= 4'h8;
        end else if (wr) begin
            if (addr == ADDR_CFG) ext_q <= wdata[CFG_DIM_EXT];
            if (addr == ADDR_AUX) aux_q <= wdata[AUX_EN_BIT];
            if (addr == ADDR_AUX) sc_q <= (wdata[2:0] == 3'h0) ? 4'h8 : {1'b0, wdata[2:0]};
            if (addr == ADDR_DIM) dim_q <= wdata[DIM_GROUP_BIT];
        end
    end
    reset_outputs_a: assert property ($rose(rst_n) |-> main_led_outputs == 2'b00 && aux_current_scale == 4'h8)
        else $error("outputs not at reset values");
    // sync delay of the undervoltage flag is covered by the quiet lead-in
    ext_gate_a: assert property (!undervoltage [*4] ##0 (wr && addr == ADDR_DIM && ext_q) |-> ##2 main_led_outputs == {2{$past(dim_q)}})
        else $error("external dim gate wrong");
    // past value keeps back-to-back writes from confusing the check
    aux_scale_a: assert property (wr && addr == ADDR_AUX |-> ##2 aux_current_scale == $past(sc_q))
        else $error("aux scale wrong");
    uv_off_a: assert property (undervoltage [*5] |-> main_led_outputs == 2'b00 && !aux_led_output)
        else $error("outputs on during undervoltage");
    aux_on_a: assert property ((aux_channel_enable && !undervoltage) [*5] |-> aux_led_output)
        else $error("aux not following pin");
    aux_off_a: assert property ((!aux_channel_enable && !aux_q) [*5] |-> !aux_led_output)
        else $error("aux on without enable");
    supply_clear_a: assert property ((supply_lost && !ext_q) [*5] |-> main_led_outputs == 2'b00)
        else $error("mains on after supply loss");
    dim_read_a: assert property (rd && addr == ADDR_DIM |=> rdata[DIM_GROUP_BIT] == dim_q)
        else $error("group bit readback wrong");
endmodule
bind lfd_ctrl lfd_ctrl_sva #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .STEP_UNIT_CYC(STEP_UNIT_CYC),
    .INSTANT_CYC(INSTANT_CYC), .PRESC_CYC(PRESC_CYC)) u_lfd_ctrl_sva (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .aux_channel_enable(aux_channel_enable),
    .undervoltage(undervoltage), .supply_lost(supply_lost), .main_led_outputs(main_led_outputs),
    .aux_led_output(aux_led_output), .aux_current_scale(aux_current_scale));
`default_nettype wire

// *** verif/lfd_ctrl_tb.sv ***
/* Self-checking bench for the LED fade and dimming controller.
   Assumes shortened debounce and step parameters so the run stays brief. */
`default_nettype none
module lfd_ctrl_tb import lfd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, wr, rd, aux_en, uv, sl, bounce, aux_out;
    logic [7:0] addr, wdata, rdata, ton, toff, rv, s1;
    logic [1:0] press, pins, gates;
    logic [15:0] codes;
    logic [3:0] aux_sc;
    logic [7:0] ra[8], rx[8];
    int num_errors, n_checks, lat;
    int gq[$];
    lfd_switch_model u_lfd_switch_model (.clk(clk), .press(press), .bounce(bounce), .pins(pins));
    lfd_ctrl #(.DEBOUNCE_CYC(20), .STEP_UNIT_CYC(4), .INSTANT_CYC(1), .PRESC_CYC(2)) u_lfd_ctrl (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .main_channel_enable_pins(pins), .aux_channel_enable(aux_en), .fade_on_timing_pin(ton),
        .fade_off_timing_pin(toff), .undervoltage(uv), .supply_lost(sl), .main_led_outputs(gates),
        .main_current_codes(codes), .aux_led_output(aux_out), .aux_current_scale(aux_sc));
    // free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // bus master: one-cycle strobes, gap cycle between requests
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        rv = rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        rreg(a);
        check($sformatf("reg %h", a), rv, exp);
    endtask
    // new switch level with chatter, then long enough for the filter
    task automatic pins_to(input logic [1:0] p);
        @(posedge clk);
        press <= p;
        bounce <= 1'b1;
        cyc(4);
        bounce <= 1'b0;
        cyc(50);
    endtask
    // watchdog well beyond the few thousand cycles the sequence needs
    initial begin
        cyc(20000);
        num_errors++;
        wrap_up();
    end
    // main sequence
    initial begin
        {wr, rd, aux_en, uv, sl, bounce} = 6'h00;
        addr = 8'h00;
        wdata = 8'h00;
        press = 2'b00;
        ton = 8'h00;
        toff = 8'h00;
        rst_n = 1'b0;
        ra = '{ADDR_CFG, ADDR_AUX, ADDR_FON, ADDR_FOFF, ADDR_CUR1, ADDR_DIM, ADDR_STEP, 8'h20};
        rx = '{CFG_RST, AUX_RST, FADE_RST, FADE_RST, CUR_RST, 8'h00, 8'h00, 8'h00};
        rv = 8'($urandom(32'hb40a));
        cyc(5);
        rst_n <= 1'b1;
        check("aux scale", {4'h0, aux_sc}, 8'h08);
        for (int i = 0; i < 8; i++) rchk(ra[i], rx[i]);
        // level mode, near-instant fades from zero codes, debounce still in place
        wreg(ADDR_CFG, 8'h0c);
        wreg(ADDR_FON, 8'h00);
        wreg(ADDR_FOFF, 8'h00);
        wreg(ADDR_CUR1, 8'h5a);
        s1 = 8'($urandom);
        wreg(ADDR_CUR2, s1);
        pins_to(2'b01);
        rchk(ADDR_DIM, 8'h01);
        cyc(80);
        rchk(ADDR_STEP, 8'd62);
        check("gates", {6'h0, gates}, 8'h01);
        check("level code", codes[7:0], 8'h5a);
        check("level code 2", codes[15:8], s1);
        rchk(ADDR_CUR2, s1);
        @(posedge clk);
        bounce <= 1'b1;
        cyc(3);
        bounce <= 1'b0;
        cyc(50);
        rchk(ADDR_DIM, 8'h01);
        pins_to(2'b00);
        rchk(ADDR_DIM, 8'h00);
        cyc(80);
        rchk(ADDR_STEP, 8'h00);
        check("gates", {6'h0, gates}, 8'h00);
        // one count per step: reversal mid-ramp walks down from where it was
        wreg(ADDR_FON, 8'h01);
        wreg(ADDR_FOFF, 8'h01);
        pins_to(2'b01);
        cyc(60);
        pins_to(2'b00);
        rreg(ADDR_STEP);
        s1 = rv;
        cyc(20);
        rreg(ADDR_STEP);
        check("reversal", 8'(s1 > 0 && s1 < 62 && (s1 - rv == 5 || s1 - rv == 6)), 8'h01);
        cyc(120);
        // fade-on time from a grounded timing pin despite a slow register
        wreg(ADDR_CFG, 8'h04);
        pins_to(2'b01);
        cyc(70);
        rchk(ADDR_STEP, 8'd62);
        // supply loss clears the latch before the pin fall is accepted
        @(posedge clk);
        press <= 2'b00;
        sl <= 1'b1;
        cyc(6);
        sl <= 1'b0;
        rchk(ADDR_DIM, 8'h00);
        cyc(60);
        // both on in level mode, then pulse mode toggles channel one only
        wreg(ADDR_CFG, 8'h0c);
        pins_to(2'b11);
        wreg(ADDR_CFG, 8'h0d);
        lat = 3;
        for (int i = 0; i < 3; i++) begin
            pins_to(2'b10);
            pins_to(2'b11);
            lat ^= 1;
            rchk(ADDR_DIM, 8'(lat));
        end
        // internal dimming: group bit outranks pins, pins keep-on and keep-off
        wreg(ADDR_CFG, 8'h0c);
        wreg(ADDR_DIM, 8'h00);
        cyc(50);
        // group bit was already clear: no event, channel two stays latched on
        rchk(ADDR_DIM, 8'h02);
        pins_to(2'b00);
        rchk(ADDR_DIM, 8'h00);
        wreg(ADDR_DIM, 8'h80);
        cyc(50);
        rchk(ADDR_DIM, 8'h83);
        pins_to(2'b11);
        rchk(ADDR_DIM, 8'h83);
        cyc(250);
        @(posedge clk);
        uv <= 1'b1;
        cyc(6);
        @(negedge clk);
        check("uv gates", {6'h0, gates}, 8'h00);
        rchk(ADDR_DIM, 8'h87);
        @(posedge clk);
        uv <= 1'b0;
        cyc(6);
        @(negedge clk);
        check("gates back", {6'h0, gates}, 8'h03);
        // external dimming: host refreshes group bit with random levels
        wreg(ADDR_CFG, 8'h0e);
        for (int i = 0; i < 8; i++) begin
            gq.push_back($urandom_range(1));
            wreg(ADDR_DIM, 8'(gq[$] << 7));
            @(posedge clk);
            @(negedge clk);
            check("ext gates", {6'h0, gates}, 8'(gq.pop_front() * 3));
        end
        // aux channel: pin, register bit, scale codes, random pin pwm
        @(posedge clk);
        aux_en <= 1'b1;
        cyc(5);
        @(negedge clk);
        check("aux pin", {7'h0, aux_out}, 8'h01);
        @(posedge clk);
        aux_en <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wreg(ADDR_AUX, 8'(i) | 8'h10);
            cyc(3);
            @(negedge clk);
            check("aux scale", {4'h0, aux_sc}, (i == 0) ? 8'h08 : 8'(i));
            check("aux bit", {7'h0, aux_out}, 8'h01);
        end
        wreg(ADDR_AUX, 8'h00);
        // model: aux output repeats the pin three cycles later
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            gq.push_back(int'($urandom_range(3) != 0));
            aux_en <= 1'(gq[$]);
            @(negedge clk);
            if (gq.size() > 3) check("aux pwm", {7'h0, aux_out}, 8'(gq.pop_front()));
        end
        @(posedge clk);
        aux_en <= 1'b0;
        cyc(5);
        @(negedge clk);
        check("aux off", {7'h0, aux_out}, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire

// *** verif/lfd_switch_model.sv ***
/* Mechanical switch model on the two main enable pins.
   Assumes the bench sets the settled level and asks for contact chatter. */
`default_nettype none
module lfd_switch_model (
    input wire logic clk,
    input wire logic [1:0] press,
    input wire logic bounce,
    output logic [1:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = 2'b00;
    // chatter flips contacts every cycle, far shorter than the filter
    always @(posedge clk) pins <= bounce ? ~pins : press;
endmodule
`default_nettype wire
